/* File: rtl/pbc_pkg.sv */
// constants of the port bypass channel eleven block
// assumes a 250 MHz core clock and a word-indexed wishbone map
`default_nettype none
package pbc_pkg;

  // ----------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------
  localparam logic [7:0] CTRL_IDX = 8'h2b;
  localparam logic [7:0] STAT_IDX = 8'h30;
  localparam logic [7:0] MASK_IDX = 8'h31;
  localparam logic [7:0] SRC_IDX = 8'h32;

  // ----------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------
  localparam int EN_BIT = 7;
  localparam int IE_BIT = 6;
  localparam int RSV_HI = 5;
  localparam int RSV_LO = 2;
  localparam int FB_BIT = 1;
  localparam int SD_BIT = 0;

  // ----------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------
  localparam logic EN_RST = 1'b0;
  localparam logic IE_RST = 1'b0;
  localparam logic FB_RST = 1'b1;
  localparam logic MASK_RST = 1'b1;
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam logic LEVEL_RST = 1'b1;

  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int LOSS_NS = 400;
  localparam int LOSS_CYC = LOSS_NS / CLK_NS;
  localparam int SYNC_STAGES = 3;

endpackage
`default_nettype wire

/* File: rtl/pbc_reg_if.sv */
// register access strobes between the bus slave and the channel
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface pbc_reg_if;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic [7:0] rdat;
  modport slave (output wr, output rd, output idx, output wdat, input rdat);
  modport regs (input wr, input rd, input idx, input wdat, output rdat);
endinterface
`default_nettype wire

/* File: rtl/pbc_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes pins are asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module pbc_pin_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= {WIDTH{pbc_pkg::LEVEL_RST}};
      s2_q <= {WIDTH{pbc_pkg::LEVEL_RST}};
      s3_q <= {WIDTH{pbc_pkg::LEVEL_RST}};
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level counts once two later stages agree
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_o <= {WIDTH{pbc_pkg::LEVEL_RST}};
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end

  a_level_agree: assert property (@(posedge clk_i) disable iff (!rstn_i)
    level_o != $past(level_o) |-> $past(s2_q) == $past(s3_q))
    else $error("filtered level moved without agreement");

endmodule // pbc_pin_sync
`default_nettype wire

/* File: rtl/pbc_wb_slave.sv */
// classic wishbone slave with a single registered acknowledge
// assumes 32-bit data, registers in the low byte lane
`timescale 1ns/1ps
`default_nettype none
module pbc_wb_slave (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // register strobes
  pbc_reg_if.slave regs
);
  logic take;

  // one take per request; ack high blocks a second one
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign regs.wr = take & wb_we_i & wb_sel_i[0];
  assign regs.rd = take & ~wb_we_i;
  assign regs.idx = wb_adr_i[9:2];
  assign regs.wdat = wb_dat_i[7:0];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= take;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (take) begin
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : {24'h00_0000, regs.rdat};
    end
  end

  a_ack_single: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");

endmodule // pbc_wb_slave
`default_nettype wire

/* File: rtl/pbc_chan11.sv */
// port bypass control channel eleven: control register, pin pair,
// signal detect interrupt and interrupt source register
// assumes one 250 MHz clock and a classic wishbone master
`timescale 1ns/1ps
`default_nettype none

module pbc_chan11 (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pin settings from the general pin registers
  input wire logic gpio_fb_out_i,
  input wire logic gpio_fb_oe_i,
  input wire logic gpio_sd_out_i,
  input wire logic gpio_sd_oe_i,
  // force bypass pin
  input wire logic force_bypass_pin_i,
  output logic force_bypass_pin_o,
  output logic force_bypass_pin_oe_o,
  // signal detect pin
  input wire logic signal_detect_pin_i,
  output logic signal_detect_pin_o,
  output logic signal_detect_pin_oe_o,
  // filtered levels {detect, force} for bypass select logic
  output logic [1:0] pin_level_o,
  // interrupt
  output logic irq_n_o
);

  localparam int LOSS_MAX = pbc_pkg::LOSS_CYC;

  // ----------------------------------------------------------
  // bus slave and pin synchroniser
  // ----------------------------------------------------------
  pbc_reg_if bus_if ();

  pbc_wb_slave u_wb (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .regs(bus_if.slave)
  );

  pbc_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i({signal_detect_pin_i, force_bypass_pin_i}),
    .level_o(pin_level_o)
  );

  // ----------------------------------------------------------
  // control register
  // ----------------------------------------------------------
  logic en_q;
  logic ie_q;
  logic fb_q;
  logic sd_filt;
  logic sd_prev_q;
  logic sd_edge;
  logic ctrl_wr;

  assign sd_filt = pin_level_o[1];
  assign ctrl_wr = bus_if.wr && bus_if.idx == pbc_pkg::CTRL_IDX;

  // bits 5..2 and bit 0 have no storage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_q <= pbc_pkg::EN_RST;
      ie_q <= pbc_pkg::IE_RST;
    end else if (ctrl_wr) begin
      en_q <= bus_if.wdat[pbc_pkg::EN_BIT];
      ie_q <= bus_if.wdat[pbc_pkg::IE_BIT];
    end
  end

  // loss of signal while enabled clears the bit and wins over a write
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fb_q <= pbc_pkg::FB_RST;
    end else if (en_q && !sd_filt) begin
      fb_q <= 1'b0;
    end else if (ctrl_wr) begin
      fb_q <= bus_if.wdat[pbc_pkg::FB_BIT];
    end
  end

  // ----------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------
  // enabled: force pin push-pull from the bit, detect pin input only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      force_bypass_pin_o <= 1'b0;
      force_bypass_pin_oe_o <= 1'b0;
    end else if (en_q) begin
      force_bypass_pin_o <= fb_q;
      force_bypass_pin_oe_o <= 1'b1;
    end else begin
      force_bypass_pin_o <= gpio_fb_out_i;
      force_bypass_pin_oe_o <= gpio_fb_oe_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      signal_detect_pin_o <= 1'b0;
      signal_detect_pin_oe_o <= 1'b0;
    end else if (en_q) begin
      signal_detect_pin_o <= 1'b0;
      signal_detect_pin_oe_o <= 1'b0;
    end else begin
      signal_detect_pin_o <= gpio_sd_out_i;
      signal_detect_pin_oe_o <= gpio_sd_oe_i;
    end
  end

  // ----------------------------------------------------------
  // signal detect interrupt
  // ----------------------------------------------------------
  logic stat_q;
  logic mask_q;
  logic [7:0] src_q;
  logic sd_evt;
  logic stat_rd;

  assign sd_edge = sd_filt ^ sd_prev_q;
  assign sd_evt = en_q & ie_q & sd_edge;
  assign stat_rd = bus_if.rd && bus_if.idx == pbc_pkg::STAT_IDX;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sd_prev_q <= pbc_pkg::LEVEL_RST;
    end else begin
      sd_prev_q <= sd_filt;
    end
  end

  // a new event wins over the clearing read
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_q <= 1'b0;
    end else if (sd_evt) begin
      stat_q <= 1'b1;
    end else if (stat_rd) begin
      stat_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_q <= pbc_pkg::MASK_RST;
    end else if (bus_if.wr && bus_if.idx == pbc_pkg::MASK_IDX) begin
      mask_q <= bus_if.wdat[0];
    end
  end

  // source register names the channel that raised the interrupt
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_q <= pbc_pkg::SRC_RST;
    end else if (sd_evt) begin
      src_q <= pbc_pkg::CTRL_IDX;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_n_o <= 1'b1;
    end else begin
      irq_n_o <= ~(stat_q & mask_q);
    end
  end

  // ----------------------------------------------------------
  // read data
  // ----------------------------------------------------------
  always_comb begin
    bus_if.rdat = 8'h00;
    case (bus_if.idx)
      pbc_pkg::CTRL_IDX: begin
        bus_if.rdat[pbc_pkg::EN_BIT] = en_q;
        bus_if.rdat[pbc_pkg::IE_BIT] = ie_q;
        bus_if.rdat[pbc_pkg::FB_BIT] = fb_q;
        bus_if.rdat[pbc_pkg::SD_BIT] = sd_filt;
      end
      pbc_pkg::STAT_IDX: begin
        bus_if.rdat[0] = stat_q;
      end
      pbc_pkg::MASK_IDX: begin
        bus_if.rdat[0] = mask_q;
      end
      pbc_pkg::SRC_IDX: begin
        bus_if.rdat = src_q;
      end
      default: begin
        bus_if.rdat = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_fb_pin_drive: assert property (
    en_q |=> force_bypass_pin_oe_o && force_bypass_pin_o == $past(fb_q))
    else $error("force pin not driven from the bit while enabled");

  a_sd_pin_input: assert property (
    en_q |=> !signal_detect_pin_oe_o)
    else $error("detect pin driven while enabled");

  a_gpio_pass: assert property (
    !en_q |=> force_bypass_pin_oe_o == $past(gpio_fb_oe_i)
      && signal_detect_pin_oe_o == $past(gpio_sd_oe_i)
      && force_bypass_pin_o == $past(gpio_fb_out_i))
    else $error("disabled channel altered the pin settings");

  a_irq_on_edge: assert property (
    en_q && ie_q && $changed(sd_filt) |=> stat_q && src_q == 8'h2b)
    else $error("detect transition did not raise the interrupt");

  a_no_irq_off: assert property (
    !(en_q && ie_q) && !stat_q |=> !stat_q)
    else $error("interrupt raised while detect interrupt disabled");

  a_irq_pin_low: assert property (
    stat_q && mask_q |=> !irq_n_o)
    else $error("interrupt output not asserted");

  a_loss_clears: assert property (
    en_q && !sd_filt |=> !fb_q)
    else $error("force bypass bit survived loss of signal");

  a_loss_latency: assert property (
    en_q && $fell(sd_filt) |-> ##[1:LOSS_MAX] !force_bypass_pin_o)
    else $error("force pin not deasserted within the loss bound");

  a_ctrl_read: assert property (
    bus_if.rd && bus_if.idx == 8'h2b
      |=> wb_dat_o[5:2] == 4'h0 && wb_dat_o[0] == $past(sd_filt))
    else $error("control read shows reserved bits or wrong detect bit");

  a_fb_normal: assert property (
    en_q && fb_q && sd_filt ##1 en_q |-> force_bypass_pin_o)
    else $error("force pin not high for normal mode");

  a_sd_pin_low: assert property (
    en_q |=> !signal_detect_pin_o)
    else $error("detect pin output not parked while enabled");

  a_gpio_sd_out: assert property (
    !en_q |=> signal_detect_pin_o == $past(gpio_sd_out_i))
    else $error("disabled channel altered the detect pin value");

  a_irq_masked: assert property (
    !(stat_q && mask_q) |=> irq_n_o)
    else $error("interrupt output asserted with no unmasked event");

  a_src_hold: assert property (
    !sd_evt |=> $stable(src_q))
    else $error("source register moved without an event");

  a_stat_clear: assert property (
    stat_rd && !sd_evt |=> !stat_q)
    else $error("status not cleared by its read");

endmodule // pbc_chan11
`default_nettype wire

/* File: verif/pbc_far_model.sv */
// far-side model: bypass circuit fed by the force pin, driving signal detect
// assumes the force pin level given to it already includes the pin pull-up
`timescale 1ns/1ps
`default_nettype none
module pbc_far_model (
  // force input and link state
  input wire logic force_level_i,
  input wire logic present_i,
  // detect output and loop state
  output logic sd_o,
  output logic bypassed_o
);
  // force input is active low: a high pin keeps the loop in normal mode
  assign bypassed_o = ~force_level_i;
  assign sd_o = present_i;
endmodule // pbc_far_model
`default_nettype wire

/* File: verif/port_bypass_channel_control_bench.sv */
// directed tests of channel eleven through classic wishbone accesses
// assumes the far-side model drives the detect pin and the force pin has a pull-up
`timescale 1ns/1ps
`default_nettype none
module port_bypass_channel_control_bench;
  logic clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic gpio_fb_out_i, gpio_fb_oe_i, gpio_sd_out_i, gpio_sd_oe_i;
  logic force_bypass_pin_o, force_bypass_pin_oe_o, signal_detect_pin_o, signal_detect_pin_oe_o;
  logic [1:0] pin_level_o;
  logic irq_n_o, present, far_sd, bypassed, fb_level, sd_level;
  int errors, n_checks;

  assign fb_level = force_bypass_pin_oe_o ? force_bypass_pin_o : 1'b1;
  assign sd_level = signal_detect_pin_oe_o ? signal_detect_pin_o : far_sd;

  pbc_chan11 i_pbc_chan11 (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .gpio_fb_out_i(gpio_fb_out_i), .gpio_fb_oe_i(gpio_fb_oe_i),
    .gpio_sd_out_i(gpio_sd_out_i), .gpio_sd_oe_i(gpio_sd_oe_i), .force_bypass_pin_i(fb_level),
    .force_bypass_pin_o(force_bypass_pin_o), .force_bypass_pin_oe_o(force_bypass_pin_oe_o),
    .signal_detect_pin_i(sd_level), .signal_detect_pin_o(signal_detect_pin_o),
    .signal_detect_pin_oe_o(signal_detect_pin_oe_o), .pin_level_o(pin_level_o), .irq_n_o(irq_n_o));

  pbc_far_model i_pbc_far_model (.force_level_i(fb_level), .present_i(present), .sd_o(far_sd),
    .bypassed_o(bypassed));

  // ----------------------------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    give_verdict();
  end

  task automatic give_verdict();
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  task automatic bus(input logic we, input logic [3:0] sel, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk("wb_ack_o", 32'h00000001, {31'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    bus(1'b1, 4'h1, idx, wd, d);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    bus(1'b0, 4'h1, idx, 8'h00, d);
    chk(name, {24'h000000, exp}, d);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic set_present(input logic v);
    @(posedge clk_i);
    present <= v;
  endtask

  // which 1 watches irq_n_o, 0 the force pin; gives up after lim cycles
  task automatic wait_for(input int which, input logic v, input int lim);
    int n;
    logic s;
    n = 0;
    s = which ? irq_n_o : force_bypass_pin_o;
    while (s !== v && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
      s = which ? irq_n_o : force_bypass_pin_o;
    end
    chk(which ? "irq_n_o" : "force_bypass_pin_o", {31'h0, v}, {31'h0, s});
  endtask

  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    logic [31:0] d;
    errors = 0;
    n_checks = 0;
    rstn_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    gpio_fb_out_i = 1'b0;
    gpio_fb_oe_i = 1'b1;
    gpio_sd_out_i = 1'b1;
    gpio_sd_oe_i = 1'b0;
    present = 1'b1;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_chk("ctrl", pbc_pkg::CTRL_IDX, 8'h03);
    rd_chk("status", pbc_pkg::STAT_IDX, 8'h00);
    rd_chk("mask", pbc_pkg::MASK_IDX, 8'h01);
    rd_chk("source", pbc_pkg::SRC_IDX, 8'h00);
    rd_chk("unmapped", 8'h2a, 8'h00);
    // disabled channel leaves the pins to the general pin settings
    wr(pbc_pkg::CTRL_IDX, 8'h42);
    settle();
    chk("fb pin", 32'h0, {31'h0, force_bypass_pin_o});
    chk("fb oe", 32'h1, {31'h0, force_bypass_pin_oe_o});
    set_present(1'b0);
    repeat (12) @(posedge clk_i);
    #1;
    chk("irq_n_o", 32'h1, {31'h0, irq_n_o});
    rd_chk("status", pbc_pkg::STAT_IDX, 8'h00);
    set_present(1'b1);
    repeat (12) @(posedge clk_i);
    chk("pin levels", 32'h2, {30'h0, pin_level_o});
    // read back the earlier write, then write enable with only the force bit set
    gpio_sd_oe_i <= 1'b1;
    rd_chk("ctrl", pbc_pkg::CTRL_IDX, 8'h43);
    chk("sd oe", 32'h1, {31'h0, signal_detect_pin_oe_o});
    chk("sd pin", 32'h1, {31'h0, signal_detect_pin_o});
    wr(pbc_pkg::CTRL_IDX, 8'h82);
    settle();
    chk("fb pin", 32'h1, {31'h0, force_bypass_pin_o});
    chk("fb oe", 32'h1, {31'h0, force_bypass_pin_oe_o});
    chk("sd oe", 32'h0, {31'h0, signal_detect_pin_oe_o});
    chk("sd pin", 32'h0, {31'h0, signal_detect_pin_o});
    chk("bypassed", 32'h0, {31'h0, bypassed});
    rd_chk("ctrl", pbc_pkg::CTRL_IDX, 8'h83);
    wr(pbc_pkg::CTRL_IDX, 8'h80);
    settle();
    chk("fb pin", 32'h0, {31'h0, force_bypass_pin_o});
    chk("bypassed", 32'h1, {31'h0, bypassed});
    wr(pbc_pkg::CTRL_IDX, 8'hbe);
    rd_chk("ctrl", pbc_pkg::CTRL_IDX, 8'h83);
    // a write without the low byte lane must leave the register alone
    bus(1'b1, 4'he, pbc_pkg::CTRL_IDX, 8'h02, d);
    rd_chk("ctrl", pbc_pkg::CTRL_IDX, 8'h83);
    // loss of signal with detect interrupt disabled
    set_present(1'b0);
    wait_for(0, 1'b0, pbc_pkg::LOSS_CYC);
    rd_chk("ctrl", pbc_pkg::CTRL_IDX, 8'h80);
    wr(pbc_pkg::CTRL_IDX, 8'h82);
    rd_chk("ctrl", pbc_pkg::CTRL_IDX, 8'h80);
    chk("pin levels", 32'h0, {30'h0, pin_level_o});
    chk("irq_n_o", 32'h1, {31'h0, irq_n_o});
    rd_chk("status", pbc_pkg::STAT_IDX, 8'h00);
    set_present(1'b1);
    repeat (12) @(posedge clk_i);
    // detect interrupt in both directions, source, clear, mask
    wr(pbc_pkg::CTRL_IDX, 8'hc2);
    rd_chk("status", pbc_pkg::STAT_IDX, 8'h00);
    set_present(1'b0);
    wait_for(1, 1'b0, 20);
    rd_chk("source", pbc_pkg::SRC_IDX, 8'h2b);
    rd_chk("status", pbc_pkg::STAT_IDX, 8'h01);
    wait_for(1, 1'b1, 3);
    rd_chk("status", pbc_pkg::STAT_IDX, 8'h00);
    set_present(1'b1);
    wait_for(1, 1'b0, 20);
    wr(pbc_pkg::MASK_IDX, 8'h00);
    wait_for(1, 1'b1, 3);
    rd_chk("status", pbc_pkg::STAT_IDX, 8'h01);
    set_present(1'b0);
    repeat (12) @(posedge clk_i);
    #1;
    chk("irq_n_o", 32'h1, {31'h0, irq_n_o});
    wr(pbc_pkg::MASK_IDX, 8'h01);
    wait_for(1, 1'b0, 3);
    rd_chk("status", pbc_pkg::STAT_IDX, 8'h01);
    wait_for(1, 1'b1, 3);
    give_verdict();
  end
endmodule // port_bypass_channel_control_bench
`default_nettype wire
